// ===== downstream_node_model.sv
// Behavioural model of the next device down the line.
// Assumes the block's clock; telegrams come back after DELAY cycles (2 or more).
`timescale 1ns/1ps
module downstream_node_model #(
  parameter int DELAY = 2
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Processing direction in, return direction out
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o
);
  logic [DELAY-1:0] vld_reg;
  logic [7:0]       dat_reg [DELAY];
  // Acts as last device: every telegram goes back on the return pair
  // Idle data toggles so a stale byte is never mistaken for a fresh one
  always_ff @(posedge clk_i) begin
    vld_reg    <= rst_i ? '0 : {vld_reg[DELAY-2:0], rx_valid_i};
    dat_reg[0] <= rst_i ? 8'h00 : (rx_valid_i ? rx_data_i : ~dat_reg[0]);
    for (int i = 1; i < DELAY; i++) dat_reg[i] <= dat_reg[i-1];
  end
  assign tx_valid_o = vld_reg[DELAY-1];
  assign tx_data_o  = dat_reg[DELAY-1];
endmodule : downstream_node_model

// ===== fieldbus_slave_state_control.sv
// Start-up state control, frame forwarding and object access of the slave.
// Assumes a 200 MHz clock; the local parameter-edit switch is asynchronous.
`timescale 1ns/1ps

module fieldbus_slave_state_control
  import slave_state_pkg::*;
#(
  parameter int          OP_CONFIRM_CYCLES = OP_CONFIRM_CYC,
  parameter logic [31:0] VENDOR_ID         = 32'h0000ABCD  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,

  // State requests from the master
  input  wire logic        state_req_valid_i,
  input  wire logic [3:0]  state_req_i,
  input  wire logic        error_ack_i,
  output logic [3:0]       state_o,
  output logic             error_o,
  output logic [7:0]       status_code_o,

  // Station address
  input  wire logic        station_addr_wr_i,
  input  wire logic [15:0] station_addr_i,
  output logic [15:0]      station_addr_o,

  // Mailbox service requests
  input  wire logic        mbx_valid_i,
  input  wire logic        mbx_pdo_i,
  input  wire logic        mbx_write_i,
  input  wire logic [15:0] mbx_index_i,
  input  wire logic [7:0]  mbx_sub_i,
  output logic             mbx_resp_valid_o,
  output logic             mbx_resp_abort_o,
  output logic [31:0]      mbx_resp_data_o,

  // Process output data from the master
  input  wire logic        pd_out_valid_i,
  input  wire logic [31:0] pd_out_data_i,
  output logic             app_out_valid_o,
  output logic [31:0]      app_out_data_o,

  // Process input data to the master
  input  wire logic        pd_cycle_i,
  input  wire logic [31:0] position_i,
  input  wire logic [31:0] velocity_i,
  input  wire logic [31:0] pos_status_i,
  output logic             pd_in_valid_o,
  output logic [63:0]      pos_image_o,
  output logic [63:0]      vel_image_o,

  // Local parameter editing switch
  input  wire logic        param_edit_i,
  output logic             comm_suspended_o,

  // Frame path
  input  wire logic        frame_in_valid_i,
  input  wire logic [7:0]  frame_in_data_i,
  input  wire logic        return_in_valid_i,
  input  wire logic [7:0]  return_in_data_i,
  input  wire logic        downstream_link_i,
  output logic             fwd_valid_o,
  output logic [7:0]       fwd_data_o,
  output logic             ret_valid_o,
  output logic [7:0]       ret_data_o
);

  localparam int          TMO_W    = $clog2(OP_CONFIRM_CYCLES + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(OP_CONFIRM_CYCLES - 1);

  al_state_t        state_reg, state_next;
  logic [7:0]       init_cnt_reg;
  logic             init_done_reg;
  logic             edit_meta_reg;
  logic             edit_sync_reg;
  logic             op_pend_reg, op_pend_next;
  logic [TMO_W-1:0] tmo_cnt_reg;
  logic             error_reg;
  logic [7:0]       status_reg, status_next;

  logic [15:0]      station_reg;
  logic             app_valid_reg;
  logic [31:0]      app_data_reg;
  logic             fwd_valid_reg;
  logic             ret_valid_reg;
  logic [7:0]       fwd_data_reg;
  logic [7:0]       ret_data_reg;
  logic             err_set;

  // Decoding of the requested transition
  wire req_ok      = state_req_valid_i && init_done_reg && !edit_sync_reg;
  wire req_legal   = (state_req_i == ST_INIT)   || (state_req_i == ST_PREOP) ||
                     (state_req_i == ST_SAFEOP) || (state_req_i == ST_OP);
  wire req_down    = req_legal && (state_req_i < state_reg);
  wire req_up_one  = req_legal && (state_req_i == {state_reg[2:0], 1'b0});
  wire req_same    = state_req_i == state_reg;
  wire req_to_op   = req_up_one && (state_reg == ST_SAFEOP);
  wire req_refused = req_ok && !req_down && !req_up_one && !req_same;

  wire tmo_hit     = op_pend_reg && (tmo_cnt_reg == TMO_LAST);
  wire pd_seen     = op_pend_reg && pd_out_valid_i && !edit_sync_reg;
  wire in_op       = (state_reg == ST_OP) && !edit_sync_reg;

  wire mbx_allowed = (state_reg != ST_INIT) && init_done_reg;
  wire addr_window = (state_reg == ST_INIT) || (state_reg == ST_PREOP);
  wire mbx_take    = mbx_valid_i && !edit_sync_reg;

  // State sequencing
  always_comb begin
    state_next   = state_reg;
    op_pend_next = op_pend_reg;
    status_next  = status_reg;
    err_set      = 1'b0;

    if (op_pend_reg && pd_seen) begin
      state_next   = ST_OP;
      op_pend_next = 1'b0;
      status_next  = STAT_OK;
    end else if (tmo_hit) begin
      op_pend_next = 1'b0;
      err_set      = 1'b1;
      status_next  = STAT_NO_OUTPUTS;
    end

    // Same-cycle request overrides the confirmation
    if (req_ok) begin
      if (req_to_op) begin
        op_pend_next = 1'b1;
      end else if (req_up_one || req_down) begin
        state_next   = al_state_t'(state_req_i);
        op_pend_next = 1'b0;
        status_next  = STAT_OK;
      end else if (req_refused) begin
        err_set      = 1'b1;
        status_next  = STAT_BAD_STEP;
      end
    end else if (state_req_valid_i && !init_done_reg) begin
      err_set     = 1'b1;
      status_next = STAT_NOT_READY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_INIT;
      op_pend_reg <= 1'b0;
      status_reg  <= STAT_OK;
    end else begin
      state_reg   <= state_next;
      op_pend_reg <= op_pend_next;
      status_reg  <= status_next;
    end
  end

  // Self-initialisation; requests before it ends are refused
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt_reg  <= 8'h00;
      init_done_reg <= 1'b0;
    end else if (!init_done_reg) begin
      init_cnt_reg  <= init_cnt_reg + 8'h01;
      init_done_reg <= init_cnt_reg == INIT_CNT_LAST;
    end
  end

  // Confirmation timeout while waiting for process data
  always_ff @(posedge clk_i) begin
    if (rst_i || !op_pend_reg) begin
      tmo_cnt_reg <= '0;
    end else begin
      tmo_cnt_reg <= tmo_cnt_reg + TMO_W'(1);
    end
  end

  // Error flag: a new fault wins over the acknowledge in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_reg <= 1'b0;
    end else begin
      error_reg <= err_set || (error_reg && !error_ack_i);
    end
  end

  // Parameter-edit switch comes from a panel, so synchronise it first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edit_meta_reg <= 1'b0;
      edit_sync_reg <= 1'b0;
    end else begin
      edit_meta_reg <= param_edit_i;
      edit_sync_reg <= edit_meta_reg;
    end
  end

  // Station address is taken only while the start-up window is open
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      station_reg <= STATION_RESET;
    end else if (station_addr_wr_i && addr_window && init_done_reg && !edit_sync_reg) begin
      station_reg <= station_addr_i;
    end
  end

  // Process outputs reach the application only in operational
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      app_valid_reg <= 1'b0;
      app_data_reg  <= 32'h0;
    end else begin
      app_valid_reg <= pd_out_valid_i && in_op;
      if (pd_out_valid_i && in_op) begin
        app_data_reg <= pd_out_data_i;
      end
    end
  end

  // Frames pass on while the downstream link is up and loop back otherwise, even while editing suspends the application
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_valid_reg <= 1'b0;
      fwd_data_reg  <= 8'h00;
      ret_valid_reg <= 1'b0;
      ret_data_reg  <= 8'h00;
    end else begin
      fwd_valid_reg <= frame_in_valid_i && downstream_link_i;
      fwd_data_reg  <= frame_in_data_i;
      ret_valid_reg <= downstream_link_i ? return_in_valid_i : frame_in_valid_i;
      ret_data_reg  <= downstream_link_i ? return_in_data_i : frame_in_data_i;
    end
  end

  object_dir_responder #(
    .VENDOR_ID (VENDOR_ID)
  ) u_od (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .req_valid_i  (mbx_take),
    .req_pdo_i    (mbx_pdo_i),
    .req_write_i  (mbx_write_i),
    .req_index_i  (mbx_index_i),
    .req_sub_i    (mbx_sub_i),
    .allowed_i    (mbx_allowed),
    .error_reg_i  ({7'h00, error_reg}),
    .position_i   (position_i),
    .velocity_i   (velocity_i),
    .resp_valid_o (mbx_resp_valid_o),
    .resp_abort_o (mbx_resp_abort_o),
    .resp_data_o  (mbx_resp_data_o)
  );

  process_input_image u_pd (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .cycle_i       (pd_cycle_i),
    .enable_i      (in_op),
    .position_i    (position_i),
    .velocity_i    (velocity_i),
    .status_i      (pos_status_i),
    .image_valid_o (pd_in_valid_o),
    .pos_image_o   (pos_image_o),
    .vel_image_o   (vel_image_o)
  );

  // Outputs
  assign state_o          = state_reg;
  assign error_o          = error_reg;
  assign status_code_o    = status_reg;
  assign station_addr_o   = station_reg;

  assign app_out_valid_o  = app_valid_reg;
  assign app_out_data_o   = app_data_reg;

  assign comm_suspended_o = edit_sync_reg;
  assign fwd_valid_o      = fwd_valid_reg;
  assign fwd_data_o       = fwd_data_reg;
  assign ret_valid_o      = ret_valid_reg;
  assign ret_data_o       = ret_data_reg;

endmodule : fieldbus_slave_state_control

// ===== fieldbus_slave_state_control_test.sv
// Self-checking bench for the slave state control.
// Assumes the bound checker and the downstream device model.
`timescale 1ns/1ps
module fieldbus_slave_state_control_test;
  import slave_state_pkg::*;
  localparam int          OPC = 20;
  localparam logic [31:0] VID = 32'h00005A5A;  // Arbitrary value
  logic        clk_i, rst_i, sv, ack, aw, mv, mp, mw, pov, pc, pe, fv, rv, lk;
  logic        er, mrv, mab, aov, piv, sus, fwv, rtv;
  logic [3:0]  sr, st;
  logic [7:0]  code, ms, fd, rd, fwd, ret, b;
  logic [15:0] ad, adq, mi, xa;
  logic [31:0] pod, pos, vel, pst, mdat, aod, d;
  logic [63:0] pim, vim;
  logic [15:0] ti [9] = '{OBJ_DEVICE_TYPE, OBJ_ERROR_REG, OBJ_IDENTITY, OBJ_POS_MAP,
                          OBJ_POS_MAP, OBJ_POS_MAP, OBJ_VEL_MAP, OBJ_VEL_MAP, OBJ_VEL_MAP};
  logic [7:0]  ts [9] = '{SUB_0, SUB_0, SUB_1, SUB_0, SUB_1, SUB_2, SUB_0, SUB_1, SUB_2};
  logic [31:0] td [9] = '{DEVICE_TYPE_VAL, 32'h0, VID, MAP_ENTRY_COUNT, POS_MAP_ENTRY1,
                          POS_MAP_ENTRY2, MAP_ENTRY_COUNT, VEL_MAP_ENTRY1, VEL_MAP_ENTRY2};
  int          n_fail, num_checks;

  fieldbus_slave_state_control #(.OP_CONFIRM_CYCLES(OPC), .VENDOR_ID(VID)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .state_req_valid_i(sv), .state_req_i(sr),
    .error_ack_i(ack), .state_o(st), .error_o(er), .status_code_o(code),
    .station_addr_wr_i(aw), .station_addr_i(ad), .station_addr_o(adq),
    .mbx_valid_i(mv), .mbx_pdo_i(mp), .mbx_write_i(mw), .mbx_index_i(mi), .mbx_sub_i(ms),
    .mbx_resp_valid_o(mrv), .mbx_resp_abort_o(mab), .mbx_resp_data_o(mdat),
    .pd_out_valid_i(pov), .pd_out_data_i(pod), .app_out_valid_o(aov), .app_out_data_o(aod),
    .pd_cycle_i(pc), .position_i(pos), .velocity_i(vel), .pos_status_i(pst),
    .pd_in_valid_o(piv), .pos_image_o(pim), .vel_image_o(vim),
    .param_edit_i(pe), .comm_suspended_o(sus), .frame_in_valid_i(fv), .frame_in_data_i(fd),
    .return_in_valid_i(rv), .return_in_data_i(rd), .downstream_link_i(lk),
    .fwd_valid_o(fwv), .fwd_data_o(fwd), .ret_valid_o(rtv), .ret_data_o(ret));
  downstream_node_model #(.DELAY(2)) u_node (.clk_i(clk_i), .rst_i(rst_i),
    .rx_valid_i(fwv), .rx_data_i(fwd), .tx_valid_o(rv), .tx_data_o(rd));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [63:0] img(input logic [31:0] v);
    return {pst, v};
  endfunction : img

  task automatic go(input logic [3:0] s);
    @(posedge clk_i);
    sv <= 1'b1;
    sr <= s;
    @(posedge clk_i);
    sv <= 1'b0;
    @(negedge clk_i);
  endtask : go

  task automatic clr;
    @(posedge clk_i);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    @(negedge clk_i);
    chk("error_cleared", er, 1'b0);
  endtask : clr

  task automatic mbx(input logic [15:0] i, input logic [7:0] s, input logic p, input logic w,
                     input logic ab, input logic [31:0] x);
    @(posedge clk_i);
    {mv, mi, ms, mp, mw} <= {1'b1, i, s, p, w};
    @(posedge clk_i);
    mv <= 1'b0;
    @(negedge clk_i);
    chk("mbx_valid", mrv, 1'b1);
    chk("mbx_abort", mab, ab);
    chk("mbx_data", mdat, x);
  endtask : mbx

  task automatic frm;
    b = 8'($urandom());
    @(posedge clk_i);
    fv <= 1'b1;
    fd <= b;
    @(posedge clk_i);
    fv <= 1'b0;
    @(negedge clk_i);
  endtask : frm

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #20000;
    n_fail++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    {sv, ack, aw, mv, mp, mw, pov, pc, pe, fv, lk, sr, ms, fd, ad, mi} = '0;
    {pod, pos, vel, pst} = '0;
    rst_i = 1'b1;
    void'($urandom(67100));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("state_reset", st, ST_INIT);
    chk("addr_reset", adq, STATION_RESET);
    go(ST_PREOP);
    chk("state_early", st, ST_INIT);
    chk("code_early", code, STAT_NOT_READY);
    mbx(OBJ_DEVICE_TYPE, SUB_0, 1'b0, 1'b0, 1'b1, ABORT_DEV_STATE);
    clr();
    repeat (110) @(posedge clk_i);
    $display("done reset and init");
    foreach (ti[k]) begin
      go(k < 5 ? ST_SAFEOP : 4'h3);
      chk("state_skip", st, ST_INIT);
      chk("code_skip", code, STAT_BAD_STEP);
      if (k == 0) clr();
    end
    clr();
    xa = 16'd1001 + 16'($urandom_range(0, 30));
    @(posedge clk_i);
    {aw, ad} <= {1'b1, xa};
    @(posedge clk_i);
    aw <= 1'b0;
    @(negedge clk_i);
    chk("station_addr", adq, xa);
    $display("done skips and address");
    go(ST_PREOP);
    chk("state_preop", st, ST_PREOP);
    @(posedge clk_i);
    {pos, vel, pst} <= {32'($urandom()), 32'($urandom()), 32'($urandom())};
    foreach (ti[k]) mbx(ti[k], ts[k], 1'b0, 1'b0, 1'b0, td[k]);
    mbx(OBJ_POSITION, SUB_0, 1'b0, 1'b0, 1'b0, pos);
    mbx(OBJ_VELOCITY, SUB_4, 1'b0, 1'b0, 1'b0, vel);
    mbx(OBJ_IDENTITY, SUB_1, 1'b0, 1'b1, 1'b1, ABORT_READ_ONLY);
    mbx(OBJ_POS_MAP, SUB_0, 1'b1, 1'b0, 1'b1, ABORT_NO_PDO_MBX);
    mbx(16'h1234, SUB_0, 1'b0, 1'b0, 1'b1, ABORT_NO_OBJECT);
    $display("done object directory");
    go(ST_SAFEOP);
    chk("state_safeop", st, ST_SAFEOP);
    @(posedge clk_i);
    {pc, pov, pod} <= {2'b11, 32'($urandom())};
    @(posedge clk_i);
    {pc, pov} <= 2'b00;
    @(negedge clk_i);
    chk("in_valid_safeop", piv, 1'b0);
    chk("image_safeop", pim, 64'h0);
    chk("out_safeop", aov, 1'b0);
    mbx(OBJ_DEVICE_TYPE, SUB_0, 1'b0, 1'b0, 1'b0, DEVICE_TYPE_VAL);
    go(ST_OP);
    repeat (OPC + 5) @(posedge clk_i);
    @(negedge clk_i);
    chk("state_no_out", st, ST_SAFEOP);
    chk("code_no_out", code, STAT_NO_OUTPUTS);
    chk("error_no_out", er, 1'b1);
    clr();
    $display("done safe operational");
    go(ST_OP);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("state_pending", st, ST_SAFEOP);
    for (int k = 0; k < 9; k++) begin
      d = $urandom();
      @(posedge clk_i);
      {pov, pod, pc, pos} <= {1'b1, d, k > 0, 32'($urandom())};
      @(posedge clk_i);
      {pov, pc} <= 2'b00;
      @(negedge clk_i);
      chk("state_op", st, ST_OP);
      if (k > 0) begin
        chk("out_data", {aov, aod}, {1'b1, d});
        chk("in_valid_op", piv, 1'b1);
        chk("pos_image", pim, img(pos));
        chk("vel_image", vim, img(vel));
      end
    end
    $display("done operational");
    @(posedge clk_i);
    {pe, lk} <= 2'b11;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("suspended", sus, 1'b1);
    @(posedge clk_i);
    mv <= 1'b1;
    @(posedge clk_i);
    mv <= 1'b0;
    @(negedge clk_i);
    chk("mbx_suspended", mrv, 1'b0);
    frm();
    chk("fwd_byte", {fwv, fwd}, {1'b1, b});
    for (int i = 0; i < 8 && rtv !== 1'b1; i++) @(negedge clk_i);
    chk("ret_byte", {rtv, ret}, {1'b1, b});
    @(posedge clk_i);
    {pe, lk} <= 2'b00;
    repeat (6) @(posedge clk_i);
    frm();
    chk("fwd_no_link", fwv, 1'b0);
    chk("loop_back", {rtv, ret}, {1'b1, b});
    go(ST_INIT);
    chk("state_down", st, ST_INIT);
    $display("done frames and suspend");
    report_and_stop();
  end
endmodule : fieldbus_slave_state_control_test

// ===== object_dir_responder.sv
// Object-directory service-data responder for mailbox requests.
// Assumes one request per cycle at most and answers on the following cycle.
`timescale 1ns/1ps
module object_dir_responder
  import slave_state_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID = 32'h0000ABCD  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Request
  input  wire logic        req_valid_i,
  input  wire logic        req_pdo_i,
  input  wire logic        req_write_i,
  input  wire logic [15:0] req_index_i,
  input  wire logic [7:0]  req_sub_i,
  input  wire logic        allowed_i,
  // Live values
  input  wire logic [7:0]  error_reg_i,
  input  wire logic [31:0] position_i,
  input  wire logic [31:0] velocity_i,
  // Answer
  output logic             resp_valid_o,
  output logic             resp_abort_o,
  output logic [31:0]      resp_data_o
);

  logic        hit;
  logic [31:0] rd_val;

  // Position and velocity are directory entries; the status value mapped into both images is not
  assign {hit, rd_val} =
    (req_index_i == OBJ_DEVICE_TYPE)                           ? {1'b1, DEVICE_TYPE_VAL} :
    (req_index_i == OBJ_ERROR_REG)                             ? {1'b1, 24'h0, error_reg_i} :
    (req_index_i == OBJ_IDENTITY    && req_sub_i == SUB_1)     ? {1'b1, VENDOR_ID} :
    ((req_index_i == OBJ_POS_MAP || req_index_i == OBJ_VEL_MAP) && req_sub_i == SUB_0)
                                                               ? {1'b1, MAP_ENTRY_COUNT} :
    (req_index_i == OBJ_POS_MAP     && req_sub_i == SUB_1)     ? {1'b1, POS_MAP_ENTRY1} :
    (req_index_i == OBJ_POS_MAP     && req_sub_i == SUB_2)     ? {1'b1, POS_MAP_ENTRY2} :
    (req_index_i == OBJ_VEL_MAP     && req_sub_i == SUB_1)     ? {1'b1, VEL_MAP_ENTRY1} :
    (req_index_i == OBJ_VEL_MAP     && req_sub_i == SUB_2)     ? {1'b1, VEL_MAP_ENTRY2} :
    (req_index_i == OBJ_POSITION)                              ? {1'b1, position_i} :
    (req_index_i == OBJ_VELOCITY    && req_sub_i == SUB_4)     ? {1'b1, velocity_i} :
                                                                 {1'b0, 32'h0};

  wire        abort_now = !allowed_i || req_pdo_i || !hit || req_write_i;
  wire [31:0] abort_val = !allowed_i ? ABORT_DEV_STATE :
                          req_pdo_i  ? ABORT_NO_PDO_MBX :
                          !hit       ? ABORT_NO_OBJECT : ABORT_READ_ONLY;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_valid_o <= 1'b0;
      resp_abort_o <= 1'b0;
      resp_data_o  <= 32'h0;
    end else begin
      resp_valid_o <= req_valid_i;
      if (req_valid_i) begin
        resp_abort_o <= abort_now;
        resp_data_o  <= abort_now ? abort_val : rd_val;
      end
    end
  end

endmodule : object_dir_responder

// ===== process_input_image.sv
// Builds the two transmit process-data images from live sensor values.
// Assumes the sensor values are on the same clock as the block.
`timescale 1ns/1ps
module process_input_image
  import slave_state_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        cycle_i,
  input  wire logic        enable_i,
  // Sensor values
  input  wire logic [31:0] position_i,
  input  wire logic [31:0] velocity_i,
  input  wire logic [31:0] status_i,
  // Images
  output logic             image_valid_o,
  output logic [63:0]      pos_image_o,
  output logic [63:0]      vel_image_o
);

  // Images are cleared on each cycle pulse outside operational and hold their value between pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      image_valid_o <= 1'b0;
      pos_image_o   <= 64'h0;
      vel_image_o   <= 64'h0;
    end else if (cycle_i) begin
      image_valid_o <= enable_i;
      pos_image_o   <= enable_i ? {status_i, position_i} : 64'h0;
      vel_image_o   <= enable_i ? {status_i, velocity_i} : 64'h0;
    end
  end

endmodule : process_input_image

// ===== slave_state_pkg.sv
// Shared constants and types for the fieldbus slave state control.
// Assumes a single 200 MHz clock domain and a synchronous active-high reset.
package slave_state_pkg;

  // Application-layer states, one-hot codes as carried on the link
  typedef enum logic [3:0] {
    ST_INIT   = 4'b0001,
    ST_PREOP  = 4'b0010,
    ST_SAFEOP = 4'b0100,
    ST_OP     = 4'b1000
  } al_state_t;

  // Status codes reported beside the state
  localparam logic [7:0] STAT_OK           = 8'h00;
  localparam logic [7:0] STAT_BAD_STEP     = 8'h11;
  localparam logic [7:0] STAT_NOT_READY    = 8'h12;
  localparam logic [7:0] STAT_NO_OUTPUTS   = 8'h1B;

  // Clock and timing
  localparam int          CLK_MHZ           = 200;
  localparam int          INIT_TIME_NS      = 500;
  localparam int          INIT_CYCLES       = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  INIT_CNT_LAST     = 8'(INIT_CYCLES - 1);
  localparam int          OP_CONFIRM_US     = 100;
  localparam int          OP_CONFIRM_CYC    = OP_CONFIRM_US * CLK_MHZ;

  // Object directory indices
  localparam logic [15:0] OBJ_DEVICE_TYPE   = 16'h1000;
  localparam logic [15:0] OBJ_ERROR_REG     = 16'h1001;
  localparam logic [15:0] OBJ_IDENTITY      = 16'h1018;
  localparam logic [15:0] OBJ_POS_MAP       = 16'h1A00;
  localparam logic [15:0] OBJ_VEL_MAP       = 16'h1A02;
  localparam logic [15:0] OBJ_VELOCITY      = 16'h2020;
  localparam logic [15:0] OBJ_POSITION      = 16'h6004;

  // Object contents
  localparam logic [31:0] DEVICE_TYPE_VAL   = 32'h00080196;
  localparam logic [31:0] MAP_ENTRY_COUNT   = 32'h00000002;
  localparam logic [31:0] POS_MAP_ENTRY1    = 32'h60040020;
  localparam logic [31:0] POS_MAP_ENTRY2    = 32'h20600120;
  localparam logic [31:0] VEL_MAP_ENTRY1    = 32'h20200420;
  localparam logic [31:0] VEL_MAP_ENTRY2    = 32'h20600120;
  localparam logic [7:0]  SUB_0             = 8'h00;
  localparam logic [7:0]  SUB_1             = 8'h01;
  localparam logic [7:0]  SUB_2             = 8'h02;
  localparam logic [7:0]  SUB_4             = 8'h04;

  // Service-data abort codes
  localparam logic [31:0] ABORT_READ_ONLY   = 32'h06010002;
  localparam logic [31:0] ABORT_NO_OBJECT   = 32'h06020000;
  localparam logic [31:0] ABORT_NO_PDO_MBX  = 32'h06040041;
  localparam logic [31:0] ABORT_DEV_STATE   = 32'h08000022;

  localparam int          ADDR_W            = 16;
  localparam int          DATA_W            = 32;
  localparam logic [15:0] STATION_RESET     = 16'h0000;

endpackage : slave_state_pkg

// ===== slave_state_sva.sv
// Port-level assertions for the slave state control.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module slave_state_sva
  import slave_state_pkg::*;
#(
  parameter int OP_CONFIRM_CYCLES = OP_CONFIRM_CYC
) (
  // Clock, reset, state
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        state_req_valid_i,
  input wire logic [3:0]  state_req_i,
  input wire logic [3:0]  state_o,
  input wire logic        error_o,
  // Mailbox
  input wire logic        mbx_valid_i,
  input wire logic        mbx_pdo_i,
  input wire logic        mbx_resp_valid_o,
  input wire logic        mbx_resp_abort_o,
  input wire logic [31:0] mbx_resp_data_o,
  // Process data and frames
  input wire logic        pd_out_valid_i,
  input wire logic [31:0] pd_out_data_i,
  input wire logic        app_out_valid_o,
  input wire logic [31:0] app_out_data_o,
  input wire logic        pd_cycle_i,
  input wire logic        pd_in_valid_o,
  input wire logic [63:0] pos_image_o,
  input wire logic        comm_suspended_o,
  input wire logic        frame_in_valid_i,
  input wire logic [7:0]  frame_in_data_i,
  input wire logic        downstream_link_i,
  input wire logic        fwd_valid_o,
  input wire logic [7:0]  fwd_data_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire skip_up = state_req_valid_i && !comm_suspended_o &&
                 ((state_o == ST_INIT && state_req_i[3:2] != 2'b00) ||
                  (state_o == ST_PREOP && state_req_i[3]));
  wire in_op   = (state_o == ST_OP) && !comm_suspended_o;

  init_on_reset_a: assert property (disable iff (1'b0) rst_i |=> state_o == ST_INIT && !error_o)
    else $error("state not INIT after reset");
  skip_refused_a: assert property (skip_up |=> $stable(state_o) && error_o)
    else $error("skipped step not refused");
  op_after_data_a: assert property ($rose(state_o == ST_OP) |-> $past(pd_out_valid_i))
    else $error("OP entered without process data");
  init_no_mbx_a: assert property (mbx_valid_i && !comm_suspended_o && state_o == ST_INIT
    |=> mbx_resp_valid_o && mbx_resp_abort_o && mbx_resp_data_o == ABORT_DEV_STATE)
    else $error("mailbox served in INIT");
  mbx_answer_a: assert property (mbx_valid_i && !comm_suspended_o |=> mbx_resp_valid_o)
    else $error("mailbox request unanswered");
  mbx_pdo_ref_a: assert property (mbx_valid_i && mbx_pdo_i && !comm_suspended_o &&
    state_o != ST_INIT |=> mbx_resp_abort_o && mbx_resp_data_o == ABORT_NO_PDO_MBX)
    else $error("process data over mailbox accepted");
  no_inputs_a: assert property (pd_cycle_i && state_o != ST_OP
    |=> !pd_in_valid_o && pos_image_o == 64'h0)
    else $error("inputs valid outside OP");
  op_inputs_a: assert property (pd_cycle_i && in_op |=> pd_in_valid_o)
    else $error("inputs not valid in OP");
  outputs_ignored_a: assert property (pd_out_valid_i && state_o != ST_OP |=> !app_out_valid_o)
    else $error("outputs passed outside OP");
  outputs_pass_a: assert property (pd_out_valid_i && in_op
    |=> app_out_valid_o && app_out_data_o == $past(pd_out_data_i))
    else $error("outputs not passed in OP");
  suspend_mbx_a: assert property (mbx_valid_i && comm_suspended_o |=> !mbx_resp_valid_o)
    else $error("mailbox served while suspended");
  fwd_frame_a: assert property (frame_in_valid_i && downstream_link_i
    |=> fwd_valid_o && fwd_data_o == $past(frame_in_data_i))
    else $error("frame byte not forwarded");

  cover property (state_o == ST_OP && pd_in_valid_o);
  cover property (mbx_resp_valid_o && mbx_resp_abort_o);
  cover property (comm_suspended_o && fwd_valid_o);
endmodule : slave_state_sva

bind fieldbus_slave_state_control slave_state_sva #(.OP_CONFIRM_CYCLES(OP_CONFIRM_CYCLES)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .state_req_valid_i(state_req_valid_i),
  .state_req_i(state_req_i), .state_o(state_o), .error_o(error_o),
  .mbx_valid_i(mbx_valid_i), .mbx_pdo_i(mbx_pdo_i), .mbx_resp_valid_o(mbx_resp_valid_o),
  .mbx_resp_abort_o(mbx_resp_abort_o), .mbx_resp_data_o(mbx_resp_data_o),
  .pd_out_valid_i(pd_out_valid_i), .pd_out_data_i(pd_out_data_i),
  .app_out_valid_o(app_out_valid_o), .app_out_data_o(app_out_data_o),
  .pd_cycle_i(pd_cycle_i), .pd_in_valid_o(pd_in_valid_o), .pos_image_o(pos_image_o),
  .comm_suspended_o(comm_suspended_o), .frame_in_valid_i(frame_in_valid_i),
  .frame_in_data_i(frame_in_data_i), .downstream_link_i(downstream_link_i),
  .fwd_valid_o(fwd_valid_o), .fwd_data_o(fwd_data_o));
